// [rtl/rshl_top.sv]
// reference switch, position latch and home capture block with apb registers
// Function
// [RULE_01] with its bit set, the actual position is latched when the right stop input goes inactive.
// [RULE_02] with its bit set, the actual position is latched when the right stop input becomes active.
// [RULE_03] with its bit set, the left stop input also serves as home reference.
// [RULE_04] with its bit set, the right stop input also serves as home reference.
// [RULE_05] home trigger code zero takes the next encoder index pulse as home event.
// [RULE_06] codes six and nine place home in the middle of the active range, high or low active.
// [RULE_07] codes eleven and thirteen use a low active reference and place home at range start or end.
// [RULE_08] when armed, the next home event stores the actual position as home and raises latch done.
// [RULE_09] clearing the latch done event disarms home capture automatically.
// [RULE_10] with the target bit clear in positioning mode, the ramp stops at the target.
// [RULE_11] with the target bit set, the next ramp starts at once on reaching the target.
// [RULE_12] without circular mode the position spans the full signed 32-bit range.
// [RULE_13] with circular mode the position stays within minus range up to range minus one.
// [RULE_14] the right stop polarity bit makes that input low active at zero and high active at one.
// [RULE_15] in circular mode the position wraps to the opposite end of the range.
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`include "rshl_defines.svh"
module rshl_top
	import rshl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic leftStopInput,
	input wire logic rightStopInput,
	input wire logic homeRefInput,
	input wire logic encIndex,
	output logic irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [31:0] refConf;
	logic [`RSHL_ST_W-1:0] status;
	logic [`RSHL_ST_W-1:0] mask;
	logic [`RSHL_ST_W-1:0] setEv;
	logic [`RSHL_ST_W-1:0] clrEv;
	rshl_pos_t targetPosition;
	rshl_pos_t nextTarget;
	rshl_pos_t circularRange;
	rshl_pos_t latchPosition;
	rshl_pos_t homePosition;
	logic [31:0] control;
	rshl_motion_e motion;
	logic apbAccess;
	logic wrEn;
	logic [5:0] idx;
	logic [31:0] rdVal;
	logic rdHit;
	logic rightActive;
	logic rightPrev;
	logic rightRise;
	logic rightFall;
	logic leftActive;
	logic reached;
	logic moveUp;
	logic homeCapture;
	logic homeDoneCleared;
	logic continueRamp;

	rshl_core_if core();

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	rshl_pos_counter u_counter (
		.clk(clk),
		.rstn(rstn),
		.core(core.counter)
	);

	rshl_home_detect u_home (
		.clk(clk),
		.rstn(rstn),
		.core(core.home)
	);

	assign core.circularEn = refConf[`RSHL_B_CIRC]; // RULE_12 RULE_13
	assign core.circularRange = circularRange;
	assign core.homeMode = refConf[`RSHL_F_HOME_HI:`RSHL_F_HOME_LO];
	assign core.homeRefRaw = homeRefInput;
	assign core.indexPulse = encIndex;
	assign core.stopHome = (refConf[`RSHL_B_LEFT_HOME] & leftActive) // RULE_03
		| (refConf[`RSHL_B_RIGHT_HOME] & rightActive); // RULE_04

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// one wait state: read data is settled in a flop before pready
	assign apbAccess = psel & penable & ~pready;
	assign wrEn = psel & penable & pready & pwrite;
	assign idx = paddr[7:2];

	always_comb begin
		rdVal = 32'h0000_0000;
		rdHit = 1'b1;
		case (idx)
			`RSHL_IDX_CONF: rdVal = refConf;
			`RSHL_IDX_STATUS: rdVal = {29'h0000_0000, status};
			`RSHL_IDX_MASK: rdVal = {29'h0000_0000, mask};
			`RSHL_IDX_TARGET: rdVal = targetPosition;
			`RSHL_IDX_NEXT: rdVal = nextTarget;
			`RSHL_IDX_RANGE: rdVal = circularRange;
			`RSHL_IDX_ACTUAL: rdVal = core.actualPosition;
			`RSHL_IDX_LATCH: rdVal = latchPosition;
			`RSHL_IDX_HOME: rdVal = homePosition;
			`RSHL_IDX_CTRL: rdVal = control;
			default: rdHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) pready <= 1'b0;
		else pready <= apbAccess;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apbAccess) begin
			prdata <= pwrite ? 32'h0000_0000 : rdVal;
			pslverr <= ~rdHit;
		end
	end

	// ----------------------------------------
	// configuration and plain registers
	// ----------------------------------------
	assign homeDoneCleared = status[`RSHL_ST_HOME] & clrEv[`RSHL_ST_HOME] & ~setEv[`RSHL_ST_HOME];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refConf <= `RSHL_CONF_RST;
		end else begin
			if (wrEn && idx == `RSHL_IDX_CONF) refConf <= pwdata;
			// disarm wins over a concurrent write of the arm bit
			if (homeDoneCleared) refConf[`RSHL_B_ARM] <= 1'b0; // RULE_09
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask <= `RSHL_ST_W'(`RSHL_WORD_RST);
			nextTarget <= `RSHL_WORD_RST;
			circularRange <= `RSHL_WORD_RST;
			control <= `RSHL_WORD_RST;
		end else if (wrEn) begin
			case (idx)
				`RSHL_IDX_MASK: mask <= pwdata[`RSHL_ST_W-1:0];
				`RSHL_IDX_NEXT: nextTarget <= pwdata;
				`RSHL_IDX_RANGE: circularRange <= pwdata;
				`RSHL_IDX_CTRL: control <= pwdata;
				default: mask <= mask;
			endcase
		end
	end

	// ----------------------------------------
	// stop switch edges and position latch
	// ----------------------------------------
	assign rightActive = refConf[`RSHL_B_POL_R] ? rightStopInput : ~rightStopInput; // RULE_14
	assign leftActive = refConf[`RSHL_B_POL_L] ? leftStopInput : ~leftStopInput;
	assign rightRise = rightActive & ~rightPrev;
	assign rightFall = ~rightActive & rightPrev;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) rightPrev <= 1'b0;
		else rightPrev <= rightActive;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latchPosition <= `RSHL_WORD_RST;
		end else if ((rightFall && refConf[`RSHL_B_LATCH_INACT_R]) // RULE_01
			|| (rightRise && refConf[`RSHL_B_LATCH_ACT_R])) begin // RULE_02
			latchPosition <= core.actualPosition;
		end
	end

	// ----------------------------------------
	// home capture
	// ----------------------------------------
	// only the first event after arming is kept until software clears it
	assign homeCapture = core.homeEvent & refConf[`RSHL_B_ARM] & ~status[`RSHL_ST_HOME]; // RULE_08

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) homePosition <= `RSHL_WORD_RST;
		else if (homeCapture) homePosition <= core.eventPosition; // RULE_08
	end

	// ----------------------------------------
	// positioning ramp
	// ----------------------------------------
	// unit step per clock; no wrap-aware shortest path in circular mode
	assign reached = core.actualPosition == targetPosition;
	assign moveUp = core.actualPosition < targetPosition;
	assign core.stepUp = (motion == RSHL_RUN) & ~reached & moveUp;
	assign core.stepDown = (motion == RSHL_RUN) & ~reached & ~moveUp;
	assign continueRamp = refConf[`RSHL_B_POS_AT_TGT] & (nextTarget != core.actualPosition);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			motion <= RSHL_IDLE;
		end else begin
			case (motion)
				RSHL_IDLE: if (control[`RSHL_B_POS_MODE] && !reached) motion <= RSHL_RUN;
				RSHL_RUN: begin
					if (!control[`RSHL_B_POS_MODE]) motion <= RSHL_IDLE;
					else if (reached && !continueRamp) motion <= RSHL_IDLE; // RULE_10
				end
				default: motion <= RSHL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			targetPosition <= `RSHL_WORD_RST;
		end else if (motion == RSHL_RUN && reached && control[`RSHL_B_POS_MODE] && continueRamp) begin
			targetPosition <= nextTarget; // RULE_11
		end else if (wrEn && idx == `RSHL_IDX_TARGET) begin
			targetPosition <= pwdata;
		end
	end

	// ----------------------------------------
	// events and interrupt
	// ----------------------------------------
	always_comb begin
		setEv = '0;
		setEv[`RSHL_ST_HOME] = homeCapture; // RULE_08
		setEv[`RSHL_ST_LATCH] = (rightFall & refConf[`RSHL_B_LATCH_INACT_R])
			| (rightRise & refConf[`RSHL_B_LATCH_ACT_R]);
		setEv[`RSHL_ST_TGT] = (motion == RSHL_RUN) & reached;
		clrEv = (wrEn && idx == `RSHL_IDX_STATUS) ? pwdata[`RSHL_ST_W-1:0] : '0;
	end

	// set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) status <= '0;
		else status <= (status & ~clrEv) | setEv;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) irq <= 1'b0;
		else irq <= |(((status & ~clrEv) | setEv) & mask);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_latch_inactive;
		@(posedge clk) disable iff (!rstn)
		rightFall && refConf[`RSHL_B_LATCH_INACT_R] |=> latchPosition == $past(core.actualPosition);
	endproperty
	a_latch_inactive: assert property (p_latch_inactive) else $error("no latch on right inactive"); // RULE_01

	property p_latch_active;
		@(posedge clk) disable iff (!rstn)
		rightRise && refConf[`RSHL_B_LATCH_ACT_R] |=> latchPosition == $past(core.actualPosition);
	endproperty
	a_latch_active: assert property (p_latch_active) else $error("no latch on right active"); // RULE_02

	property p_no_latch;
		@(posedge clk) disable iff (!rstn)
		!(rightFall && refConf[`RSHL_B_LATCH_INACT_R]) && !(rightRise && refConf[`RSHL_B_LATCH_ACT_R])
			|=> $stable(latchPosition);
	endproperty
	a_no_latch: assert property (p_no_latch) else $error("latch without enabled edge"); // RULE_01

	property p_right_polarity;
		@(posedge clk) disable iff (!rstn)
		$stable(refConf[`RSHL_B_POL_R]) && !refConf[`RSHL_B_POL_R] && $fell(rightStopInput) |-> rightRise;
	endproperty
	a_right_polarity: assert property (p_right_polarity) else $error("low active right stop missed"); // RULE_14

	property p_left_home;
		@(posedge clk) disable iff (!rstn)
		refConf[`RSHL_F_HOME_HI:`RSHL_F_HOME_LO] == `RSHL_HM_HI_START
			&& refConf[`RSHL_B_LEFT_HOME] && $stable(refConf) && $rose(leftActive)
			&& !$past(homeRefInput) && !$past(core.stopHome) |=> core.homeEvent;
	endproperty
	a_left_home: assert property (p_left_home) else $error("left stop not used as home"); // RULE_03

	sequence s_armed_event;
		core.homeEvent && refConf[`RSHL_B_ARM] && !status[`RSHL_ST_HOME];
	endsequence
	property p_home_capture;
		@(posedge clk) disable iff (!rstn)
		s_armed_event |=> homePosition == $past(core.eventPosition) && status[`RSHL_ST_HOME];
	endproperty
	a_home_capture: assert property (p_home_capture) else $error("home capture missed"); // RULE_08

	property p_unarmed;
		@(posedge clk) disable iff (!rstn)
		!refConf[`RSHL_B_ARM] |=> $stable(homePosition);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("home stored while unarmed"); // RULE_08

	property p_disarm;
		@(posedge clk) disable iff (!rstn)
		$fell(status[`RSHL_ST_HOME]) |-> !refConf[`RSHL_B_ARM];
	endproperty
	a_disarm: assert property (p_disarm) else $error("arm bit kept after event clear"); // RULE_09

	property p_stop_at_target;
		@(posedge clk) disable iff (!rstn)
		motion == RSHL_RUN && reached && !refConf[`RSHL_B_POS_AT_TGT] |=> motion == RSHL_IDLE ##1 $stable(core.actualPosition);
	endproperty
	a_stop_at_target: assert property (p_stop_at_target) else $error("ramp did not stop at target"); // RULE_10

	property p_continue;
		@(posedge clk) disable iff (!rstn)
		motion == RSHL_RUN && reached && control[`RSHL_B_POS_MODE] && continueRamp
			|=> motion == RSHL_RUN && targetPosition == $past(nextTarget);
	endproperty
	a_continue: assert property (p_continue) else $error("next ramp not started"); // RULE_11

	property p_irq;
		@(posedge clk) disable iff (!rstn)
		|(status & mask) && !(|clrEv) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule // rshl_top

// [rtl/rshl_defines.svh]
// register offsets, field positions and reset values of the reference switch block
`ifndef RSHL_DEFINES_SVH
`define RSHL_DEFINES_SVH
// register indexes, byte address is four times the index
`define RSHL_IDX_CONF 6'h01
`define RSHL_IDX_STATUS 6'h02
`define RSHL_IDX_MASK 6'h03
`define RSHL_IDX_TARGET 6'h04
`define RSHL_IDX_NEXT 6'h05
`define RSHL_IDX_RANGE 6'h06
`define RSHL_IDX_ACTUAL 6'h07
`define RSHL_IDX_LATCH 6'h08
`define RSHL_IDX_HOME 6'h09
`define RSHL_IDX_CTRL 6'h0A
// configuration fields
`define RSHL_B_POL_L 2
`define RSHL_B_POL_R 3
`define RSHL_B_LATCH_INACT_R 12
`define RSHL_B_LATCH_ACT_R 13
`define RSHL_B_LEFT_HOME 14
`define RSHL_B_RIGHT_HOME 15
`define RSHL_F_HOME_LO 16
`define RSHL_F_HOME_HI 19
`define RSHL_B_ARM 20
`define RSHL_B_POS_AT_TGT 21
`define RSHL_B_CIRC 22
// status and control fields
`define RSHL_ST_HOME 0
`define RSHL_ST_LATCH 1
`define RSHL_ST_TGT 2
`define RSHL_ST_W 3
`define RSHL_B_POS_MODE 0
// home trigger codes
`define RSHL_HM_INDEX 4'h0
`define RSHL_HM_HI_START 4'h2
`define RSHL_HM_HI_START2 4'h3
`define RSHL_HM_HI_END 4'h4
`define RSHL_HM_HI_MID 4'h6
`define RSHL_HM_LO_MID 4'h9
`define RSHL_HM_LO_START 4'hB
`define RSHL_HM_LO_END 4'hD
// reset values
`define RSHL_CONF_RST 32'h0000_0000
`define RSHL_WORD_RST 32'h0000_0000
`endif

// [rtl/rshl_pkg.sv]
// types shared by the reference switch block
package rshl_pkg;
	typedef logic signed [31:0] rshl_pos_t;
	typedef enum logic {RSHL_IDLE, RSHL_RUN} rshl_motion_e;
	typedef enum logic [2:0] {RSHL_PL_NONE, RSHL_PL_INDEX, RSHL_PL_START, RSHL_PL_END, RSHL_PL_MID} rshl_place_e;
endpackage

// [rtl/rshl_core_if.sv]
// position and home event signals between the block's modules
`timescale 1ns/1ns
interface rshl_core_if;
	import rshl_pkg::*;
	rshl_pos_t actualPosition;
	logic stepUp;
	logic stepDown;
	logic circularEn;
	rshl_pos_t circularRange;
	logic [3:0] homeMode;
	logic homeRefRaw;
	logic stopHome;
	logic indexPulse;
	logic homeEvent;
	rshl_pos_t eventPosition;
	modport counter(input stepUp, stepDown, circularEn, circularRange, output actualPosition);
	modport home(input actualPosition, homeMode, homeRefRaw, stopHome, indexPulse, output homeEvent, eventPosition);
	modport ctrl(output stepUp, stepDown, circularEn, circularRange, homeMode, homeRefRaw, stopHome, indexPulse,
		input actualPosition, homeEvent, eventPosition);
endinterface

// [rtl/rshl_pos_counter.sv]
// actual position counter with optional circular range
`timescale 1ns/1ns
`include "rshl_defines.svh"
module rshl_pos_counter
	import rshl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	rshl_core_if.counter core
);
	rshl_pos_t rangeLow;
	rshl_pos_t rangeHigh;
	assign rangeLow = 32'sh0000_0000 - core.circularRange;
	assign rangeHigh = core.circularRange - 32'sh0000_0001;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core.actualPosition <= `RSHL_WORD_RST;
		end else if (core.stepUp) begin
			if (core.circularEn && core.actualPosition >= rangeHigh)
				core.actualPosition <= rangeLow; // RULE_13 RULE_15
			else
				core.actualPosition <= core.actualPosition + 32'sh0000_0001; // RULE_12
		end else if (core.stepDown) begin
			if (core.circularEn && core.actualPosition <= rangeLow)
				core.actualPosition <= rangeHigh; // RULE_13 RULE_15
			else
				core.actualPosition <= core.actualPosition - 32'sh0000_0001; // RULE_12
		end
	end

	property p_wrap_up;
		@(posedge clk) disable iff (!rstn)
		core.stepUp && core.circularEn && core.actualPosition == rangeHigh |=> core.actualPosition == $past(rangeLow);
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap at upper end"); // RULE_15

	property p_full_range;
		@(posedge clk) disable iff (!rstn)
		core.stepUp && !core.circularEn |=> core.actualPosition == $past(core.actualPosition) + 32'sh0000_0001;
	endproperty
	a_full_range: assert property (p_full_range) else $error("position limited without circular mode"); // RULE_12
endmodule // rshl_pos_counter

// [rtl/rshl_home_detect.sv]
// home event detection from index pulse or home reference level
`timescale 1ns/1ns
`include "rshl_defines.svh"
module rshl_home_detect
	import rshl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	rshl_core_if.home core
);
	logic lowActive;
	logic refActive;
	logic prevActive;
	logic enterRange;
	logic leaveRange;
	rshl_place_e place;
	rshl_pos_t entryPosition;
	logic signed [32:0] midSum;

	always_comb begin
		lowActive = 1'b0;
		place = RSHL_PL_NONE;
		case (core.homeMode)
			`RSHL_HM_INDEX: place = RSHL_PL_INDEX; // RULE_05
			`RSHL_HM_HI_START, `RSHL_HM_HI_START2: place = RSHL_PL_START;
			`RSHL_HM_HI_END: place = RSHL_PL_END;
			`RSHL_HM_HI_MID: place = RSHL_PL_MID; // RULE_06
			`RSHL_HM_LO_MID: begin
				place = RSHL_PL_MID; // RULE_06
				lowActive = 1'b1;
			end
			`RSHL_HM_LO_START: begin
				place = RSHL_PL_START; // RULE_07
				lowActive = 1'b1;
			end
			`RSHL_HM_LO_END: begin
				place = RSHL_PL_END; // RULE_07
				lowActive = 1'b1;
			end
			default: place = RSHL_PL_NONE;
		endcase
	end

	// a stop switch acting as home joins the reference level
	assign refActive = (lowActive ? ~core.homeRefRaw : core.homeRefRaw) | core.stopHome;
	assign enterRange = refActive & ~prevActive;
	assign leaveRange = ~refActive & prevActive;
	assign midSum = {entryPosition[31], entryPosition} + {core.actualPosition[31], core.actualPosition};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) prevActive <= 1'b0;
		else prevActive <= refActive;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) entryPosition <= `RSHL_WORD_RST;
		else if (enterRange) entryPosition <= core.actualPosition;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core.homeEvent <= 1'b0;
			core.eventPosition <= `RSHL_WORD_RST;
		end else begin
			core.homeEvent <= 1'b0;
			case (place)
				RSHL_PL_INDEX: if (core.indexPulse) begin
					core.homeEvent <= 1'b1; // RULE_05
					core.eventPosition <= core.actualPosition;
				end
				RSHL_PL_START: if (enterRange) begin
					core.homeEvent <= 1'b1; // RULE_07
					core.eventPosition <= core.actualPosition;
				end
				RSHL_PL_END: if (leaveRange) begin
					core.homeEvent <= 1'b1; // RULE_07
					core.eventPosition <= core.actualPosition;
				end
				// middle needs both ends, so it fires only on leaving the range
				RSHL_PL_MID: if (leaveRange) begin
					core.homeEvent <= 1'b1; // RULE_06
					core.eventPosition <= midSum[32:1];
				end
				default: core.homeEvent <= 1'b0;
			endcase
		end
	end

	property p_index_event;
		@(posedge clk) disable iff (!rstn)
		core.homeMode == `RSHL_HM_INDEX && core.indexPulse |=> core.homeEvent;
	endproperty
	a_index_event: assert property (p_index_event) else $error("index pulse gave no home event"); // RULE_05

	sequence s_hi_range_left;
		core.homeMode == `RSHL_HM_HI_MID && !core.stopHome && core.homeRefRaw ##1
			core.homeMode == `RSHL_HM_HI_MID && !core.stopHome && !core.homeRefRaw;
	endsequence
	property p_middle;
		@(posedge clk) disable iff (!rstn)
		s_hi_range_left |=> core.homeEvent && core.eventPosition == $past(midSum[32:1]);
	endproperty
	a_middle: assert property (p_middle) else $error("home not placed in middle"); // RULE_06
endmodule // rshl_home_detect

// [testbench/rshl_far_model.sv]
// far side model: stop switches, home reference input and encoder index
`timescale 1ns/1ns
module rshl_far_model (
	input wire logic clk,
	output logic leftStop,
	output logic rightStop,
	output logic homeRef,
	output logic encIdx
);
	// ----------------------------------------
	// switch and index drivers
	// ----------------------------------------
	// stops idle released; released low active switch reads high
	initial begin
		leftStop = 1'b1;
		rightStop = 1'b1;
		homeRef = 1'b0;
		encIdx = 1'b0;
	end
	// levels move only right after an edge, like a synchronised input
	task automatic setLevels(input logic l, input logic r, input logic h);
		@(posedge clk);
		leftStop <= l;
		rightStop <= r;
		homeRef <= h;
	endtask
	// one clock wide: the shortest index the block must still catch
	task automatic pulseIndex();
		@(posedge clk);
		encIdx <= 1'b1;
		@(posedge clk);
		encIdx <= 1'b0;
	endtask
endmodule // rshl_far_model

// [testbench/tb_top.sv]
// self-checking testbench of the reference switch block
`timescale 1ns/1ns
`include "rshl_defines.svh"
module tb_top;
	import rshl_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic leftStop, rightStop, homeRef, encIdx;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int n_fail, n_checks;
	int hmCode[9] = '{0, 6, 9, 11, 13, 2, 2, 4, 3};
	int hmSrc[9] = '{3, 0, 0, 0, 0, 1, 2, 0, 0};
	rshl_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .leftStopInput(leftStop),
		.rightStopInput(rightStop), .homeRefInput(homeRef), .encIndex(encIdx), .irq(irq));
	rshl_far_model far (.clk(clk), .leftStop(leftStop), .rightStop(rightStop), .homeRef(homeRef), .encIdx(encIdx));
	// ----------------------------------------
	// clock, tasks and verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one wait state is expected, but the master polls pready and accepts any number
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		check(what, rd, exp);
	endtask
	task automatic moveTo(input logic [31:0] p);
		int n;
		apb(1'b1, `RSHL_IDX_TARGET, p);
		n = 0;
		do begin
			apb(1'b0, `RSHL_IDX_ACTUAL, 32'h0000_0000);
			n++;
		end while (rd !== p && n < 200);
		rdchk("stopped at target", `RSHL_IDX_ACTUAL, p);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		test_done();
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		int i;
		logic [31:0] a, b, exp, cfg;
		logic lowAct, sawNeg;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		n_fail = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rdchk("conf reset", `RSHL_IDX_CONF, 32'h0000_0000);
		rdchk("position reset", `RSHL_IDX_ACTUAL, 32'h0000_0000);
		apb(1'b1, `RSHL_IDX_CONF, 32'h000B_F00C);
		rdchk("conf readback", `RSHL_IDX_CONF, 32'h000B_F00C);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_0000);
		apb(1'b0, 6'h3F, 32'h0000_0000);
		check("unmapped error", {31'h0, err}, 32'h0000_0001);
		// the readback config above raised a right stop latch flag
		apb(1'b1, `RSHL_IDX_STATUS, 32'h0000_0007);
		$display("test registers done");
		apb(1'b1, `RSHL_IDX_CTRL, 32'h0000_0001);
		moveTo(32'h0000_0005);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_2000);
		far.setLevels(1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		rdchk("latch on active", `RSHL_IDX_LATCH, 32'h0000_0005);
		apb(1'b0, `RSHL_IDX_STATUS, 32'h0000_0000);
		check("latch flag", rd & 32'h0000_0002, 32'h0000_0002);
		check("irq masked", {31'h0, irq}, 32'h0000_0000);
		apb(1'b1, `RSHL_IDX_STATUS, 32'h0000_0007);
		moveTo(32'h0000_0008);
		far.setLevels(1'b1, 1'b1, 1'b0);
		rdchk("no latch on release", `RSHL_IDX_LATCH, 32'h0000_0005);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_1000);
		moveTo(32'h0000_000C);
		far.setLevels(1'b1, 1'b0, 1'b0);
		rdchk("no latch on press", `RSHL_IDX_LATCH, 32'h0000_0005);
		far.setLevels(1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		rdchk("latch on inactive", `RSHL_IDX_LATCH, 32'h0000_000C);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_0008);
		far.setLevels(1'b1, 1'b0, 1'b0);
		moveTo(32'h0000_000F);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_2008);
		far.setLevels(1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		rdchk("high active latch", `RSHL_IDX_LATCH, 32'h0000_000F);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_0000);
		$display("test stop latch done");
		apb(1'b1, `RSHL_IDX_NEXT, 32'h0000_001E);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0020_0000);
		apb(1'b1, `RSHL_IDX_TARGET, 32'h0000_0019);
		repeat (60) @(posedge clk);
		rdchk("chained ramp", `RSHL_IDX_ACTUAL, 32'h0000_001E);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0000_0000);
		$display("test target done");
		apb(1'b1, `RSHL_IDX_MASK, 32'h0000_0001);
		for (i = 0; i < 9; i++) begin
			a = 32'(40 + i * 12);
			b = a + 32'h0000_0005;
			lowAct = hmCode[i] inside {9, 11, 13};
			cfg = {12'h000, hmCode[i][3:0], 16'h0000};
			cfg = cfg | (hmSrc[i] == 1 ? 32'h0000_8000 : hmSrc[i] == 2 ? 32'h0000_4000 : 32'h0000_0000);
			// mode set unarmed first: a new active level must not look like an edge once armed
			apb(1'b1, `RSHL_IDX_CONF, cfg);
			far.setLevels(1'b1, 1'b1, lowAct);
			moveTo(a);
			apb(1'b1, `RSHL_IDX_CONF, cfg | 32'h0010_0000);
			far.setLevels(hmSrc[i] != 2, hmSrc[i] != 1, hmSrc[i] == 0 ? ~lowAct : lowAct);
			moveTo(b);
			if (hmSrc[i] == 3)
				far.pulseIndex();
			else
				far.setLevels(1'b1, 1'b1, lowAct);
			repeat (4) @(posedge clk);
			exp = hmCode[i] inside {0, 4, 13} ? b : hmCode[i] inside {6, 9} ? a + 32'h0000_0002 : a;
			rdchk("home position", `RSHL_IDX_HOME, exp);
			check("home irq", {31'h0, irq}, 32'h0000_0001);
			apb(1'b1, `RSHL_IDX_STATUS, 32'h0000_0001);
			repeat (2) @(posedge clk);
			check("irq cleared", {31'h0, irq}, 32'h0000_0000);
			rdchk("disarmed", `RSHL_IDX_CONF, cfg);
		end
		$display("test home done");
		moveTo(32'h0000_0000);
		apb(1'b1, `RSHL_IDX_RANGE, 32'h0000_0004);
		apb(1'b1, `RSHL_IDX_CONF, 32'h0040_0000);
		apb(1'b1, `RSHL_IDX_TARGET, 32'h0000_0064);
		sawNeg = 1'b0;
		for (i = 0; i < 8; i++) begin
			apb(1'b0, `RSHL_IDX_ACTUAL, 32'h0000_0000);
			sawNeg = sawNeg | rd[31];
			check("in range", {31'h0, $signed(rd) >= -4 && $signed(rd) <= 3}, 32'h0000_0001);
		end
		check("wrapped", {31'h0, sawNeg}, 32'h0000_0001);
		$display("test circular done");
		test_done();
	end
endmodule // tb_top
